// file: design/csr_core_regs.sv
// csr_core_regs: shadow context, stack window, external interrupt flag, status
// flags and read-only information regions of a small 8-bit core.
// Assumes synchronous inputs, one-cycle strobes and single-clock core events.
//
// Behaviour
// - edge select 1 catches rising pin edge, 0 catches falling edge.
// - interrupt flag sets on its event regardless of any enable bit.
// - stack window reads and writes the entry chosen by the stack index.
// - window reachable as high and low byte registers, entries reset to zero.
// - stack index holds a five-bit location field in its low bits.
// - status shadow: bits 4,3 read-only copies, bits 2..0 read-write.
// - expiry flag 1 at power-up, clear or sleep; 0 after watchdog time-out.
// - power-down flag 1 at power-up or clear, 0 after sleep.
// - zero flag is 1 exactly when an add, subtract or logic result is zero; rotates leave it unchanged.
// - nibble carry follows carry out of low four result bits on add/sub.
// - carry follows carry out of the top result bit on add/sub.
// - subtract adds two's complement; rotates load carry from top or bottom bit.
// - working shadow is 8-bit read-write, kept across ordinary reset.
// - bank shadow is 6-bit read-write, kept across ordinary reset.
// - pc-latch shadow is 7-bit read-write, kept across ordinary reset.
// - two 16-bit indirect shadows with byte access, kept across reset.
// - configuration region is fixed, readable and never writable.
// - configuration region reports 32, 32, 128, 256 and pin total.
// - device region holds fixed identifier and calibration words, read-only.
// - global enable 1 lets interrupts through, 0 blocks them all.
`timescale 1ns/100ps
module csr_core_regs
    import csr_pkg::*;
#(
    parameter logic [13:0] PIN_TOTAL = 14'h0014,
    parameter logic [13:0] UID_SEED = 14'h1a5c,  // arbitrary value
    parameter logic [13:0] CAL_FILL = 14'h0000
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // information read port
    input wire logic info_rd,
    input wire logic [15:0] info_addr,
    output logic [13:0] info_data,
    // core events
    input wire logic irq_enter,
    input wire logic irq_return,
    input wire csr_ctx_t core_ctx,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic sleep_exec,
    input wire logic alu_valid,
    input wire csr_alu_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    // external interrupt pin
    input wire logic ext_pin,
    // outputs to core
    output csr_status_t status,
    output csr_ctx_t restore_ctx,
    output logic restore_valid,
    output logic ext_irq_flag,
    output logic irq_request
);
    // flag update from one alu operation
    function automatic csr_status_t alu_flags(csr_status_t cur, csr_alu_op_t op,
                                              logic [7:0] a, logic [7:0] b);
        csr_status_t f;
        logic [8:0] sum;
        logic [4:0] nib;
        logic [7:0] bb;
        f = cur;
        bb = (op == ALU_SUB) ? ~b : b;
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, op == ALU_SUB};
        nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op == ALU_SUB};
        unique case (op)
            ALU_ADD, ALU_SUB: begin
                f.zero = (sum[7:0] == 8'h00);
                f.nibble_carry_flag = nib[4];
                f.carry = sum[8];
            end
            ALU_LOGIC: f.zero = (a == 8'h00);
            ALU_ROTL: f.carry = a[7];
            ALU_ROTR: f.carry = a[0];
            default: f = cur;
        endcase
        return f;
    endfunction

    // read-only information words
    function automatic logic [13:0] info_word(logic [15:0] a, logic [13:0] pins,
                                              logic [13:0] seed, logic [13:0] fill);
        logic [13:0] w;
        w = 14'h0000;
        if (a >= CFG_INFO_BASE && a <= CFG_INFO_LAST) begin
            unique case (a)
                CFG_ERASE_ROW: w = ERASE_ROW_SIZE;
                CFG_WRITE_LATCH: w = WRITE_LATCH_COUNT;
                CFG_USER_ROWS: w = USER_ROW_COUNT;
                CFG_EE_SIZE: w = EEPROM_SIZE;
                CFG_PIN_TOTAL: w = pins;
                default: w = 14'h0000;
            endcase
        end else if (a >= DEV_INFO_BASE && a <= DEV_INFO_LAST) begin
            w = (a[4:0] < 5'h0a) ? (seed ^ {9'h000, a[4:0]}) : fill;
        end
        return w;
    endfunction

    // state
    logic [15:0] stack_mem_ff [STACK_DEPTH];
    logic [15:0] nxt_stack_word;
    logic stack_we;
    logic [4:0] stack_index_ff, nxt_stack_index;
    csr_status_t status_ff, nxt_status;
    logic [4:0] status_shadow_ff, nxt_status_shadow;
    csr_ctx_t ctx_shadow_ff, nxt_ctx_shadow;
    csr_ctx_t restore_ctx_ff, nxt_restore_ctx;
    logic restore_valid_ff, nxt_restore_valid;
    logic [7:0] irq_ctrl_ff, nxt_irq_ctrl;
    logic ext_flag_ff, nxt_ext_flag;
    logic pin_prev_ff, nxt_pin_prev;
    logic irq_req_ff, nxt_irq_req;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [13:0] info_ff, nxt_info;
    logic ext_edge;
    logic [15:0] stack_cur;

    assign stack_cur = stack_mem_ff[stack_index_ff];

    // register writes, shadows and stack
    always_comb begin
        nxt_stack_index = stack_index_ff;
        nxt_status_shadow = status_shadow_ff;
        nxt_ctx_shadow = ctx_shadow_ff;
        nxt_irq_ctrl = irq_ctrl_ff;
        nxt_stack_word = stack_cur;
        stack_we = 1'b0;
        if (reg_wr) begin
            unique case (reg_addr)
                ADR_STATUS_SHADOW: nxt_status_shadow[2:0] = reg_wdata[2:0];
                ADR_WORKING_SHADOW: nxt_ctx_shadow.working = reg_wdata;
                ADR_BANK_SHADOW: nxt_ctx_shadow.bank = reg_wdata[5:0];
                ADR_PCL_SHADOW: nxt_ctx_shadow.pc_latch = reg_wdata[6:0];
                ADR_IND0_LO: nxt_ctx_shadow.ind0[7:0] = reg_wdata;
                ADR_IND0_HI: nxt_ctx_shadow.ind0[15:8] = reg_wdata;
                ADR_IND1_LO: nxt_ctx_shadow.ind1[7:0] = reg_wdata;
                ADR_IND1_HI: nxt_ctx_shadow.ind1[15:8] = reg_wdata;
                ADR_STACK_INDEX: nxt_stack_index = reg_wdata[4:0];
                ADR_STACK_LO: begin
                    nxt_stack_word = {stack_cur[15:8], reg_wdata};
                    stack_we = 1'b1;
                end
                ADR_STACK_HI: begin
                    nxt_stack_word = {reg_wdata, stack_cur[7:0]};
                    stack_we = 1'b1;
                end
                ADR_IRQ_CTRL: nxt_irq_ctrl = reg_wdata;
                default: nxt_irq_ctrl = irq_ctrl_ff;
            endcase
        end
        // hardware save beats a software write in the same cycle
        if (irq_enter) begin
            nxt_status_shadow = status_ff;
            nxt_ctx_shadow = core_ctx;
        end
    end

    // shadows have no reset: their contents survive ordinary resets
    always_ff @(posedge clk) begin
        status_shadow_ff <= nxt_status_shadow;
        ctx_shadow_ff <= nxt_ctx_shadow;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem_ff[i] <= STACK_RST;
            end
            stack_index_ff <= STACK_INDEX_RST;
            irq_ctrl_ff <= IRQ_CTRL_RST;
        end else begin
            if (stack_we) begin
                stack_mem_ff[stack_index_ff] <= nxt_stack_word;
            end
            stack_index_ff <= nxt_stack_index;
            irq_ctrl_ff <= nxt_irq_ctrl;
        end
    end

    // live status, interrupt flag, restore path
    always_comb begin
        nxt_status = status_ff;
        if (alu_valid) begin
            nxt_status = alu_flags(status_ff, alu_op, alu_a, alu_b);
        end
        if (irq_return) begin
            nxt_status.zero = status_shadow_ff[2];
            nxt_status.nibble_carry_flag = status_shadow_ff[1];
            nxt_status.carry = status_shadow_ff[0];
        end
        if (wdt_clear) begin
            nxt_status.watchdog_expiry_flag = 1'b1;
            nxt_status.powerdown_flag = 1'b1;
        end
        if (sleep_exec) begin
            nxt_status.watchdog_expiry_flag = 1'b1;
            nxt_status.powerdown_flag = 1'b0;
        end
        // a time-out is the newer event, so it wins over a clear
        if (wdt_timeout) begin
            nxt_status.watchdog_expiry_flag = 1'b0;
        end
        nxt_pin_prev = ext_pin;
        ext_edge = irq_ctrl_ff[EDGE_SEL_BIT] ? (ext_pin & ~pin_prev_ff)
                                            : (~ext_pin & pin_prev_ff);
        nxt_ext_flag = ext_flag_ff;
        if (reg_wr && reg_addr == ADR_IRQ_FLAG && !reg_wdata[EXT_FLAG_BIT]) begin
            nxt_ext_flag = 1'b0;
        end
        if (ext_edge) begin
            nxt_ext_flag = 1'b1;
        end
        nxt_irq_req = nxt_ext_flag & irq_ctrl_ff[EXT_EN_BIT] & irq_ctrl_ff[GIE_BIT];
        nxt_restore_valid = irq_return;
        nxt_restore_ctx = irq_return ? ctx_shadow_ff : restore_ctx_ff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            status_ff <= STATUS_RST;
            ext_flag_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
            irq_req_ff <= 1'b0;
            restore_valid_ff <= 1'b0;
            restore_ctx_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            ext_flag_ff <= nxt_ext_flag;
            pin_prev_ff <= nxt_pin_prev;
            irq_req_ff <= nxt_irq_req;
            restore_valid_ff <= nxt_restore_valid;
            restore_ctx_ff <= nxt_restore_ctx;
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADR_STATUS_SHADOW: nxt_rdata = {3'h0, status_shadow_ff};
                ADR_WORKING_SHADOW: nxt_rdata = ctx_shadow_ff.working;
                ADR_BANK_SHADOW: nxt_rdata = {2'h0, ctx_shadow_ff.bank};
                ADR_PCL_SHADOW: nxt_rdata = {1'b0, ctx_shadow_ff.pc_latch};
                ADR_IND0_LO: nxt_rdata = ctx_shadow_ff.ind0[7:0];
                ADR_IND0_HI: nxt_rdata = ctx_shadow_ff.ind0[15:8];
                ADR_IND1_LO: nxt_rdata = ctx_shadow_ff.ind1[7:0];
                ADR_IND1_HI: nxt_rdata = ctx_shadow_ff.ind1[15:8];
                ADR_STACK_INDEX: nxt_rdata = {3'h0, stack_index_ff};
                ADR_STACK_LO: nxt_rdata = stack_cur[7:0];
                ADR_STACK_HI: nxt_rdata = stack_cur[15:8];
                ADR_IRQ_CTRL: nxt_rdata = irq_ctrl_ff;
                ADR_IRQ_FLAG: nxt_rdata = {7'h00, ext_flag_ff};
                ADR_STATUS_LIVE: nxt_rdata = {3'h0, status_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_info = info_rd ? info_word(info_addr, PIN_TOTAL, UID_SEED, CAL_FILL)
                           : 14'h0000;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
            info_ff <= 14'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
            info_ff <= nxt_info;
        end
    end

    assign reg_rdata = rdata_ff;
    assign info_data = info_ff;
    assign status = status_ff;
    assign restore_ctx = restore_ctx_ff;
    assign restore_valid = restore_valid_ff;
    assign ext_irq_flag = ext_flag_ff;
    assign irq_request = irq_req_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    rising_edge_flag_a: assert property (irq_ctrl_ff[EDGE_SEL_BIT] && !pin_prev_ff
        && ext_pin |=> ext_flag_ff) else $error("rising edge not flagged");
    falling_edge_flag_a: assert property (!irq_ctrl_ff[EDGE_SEL_BIT] && pin_prev_ff
        && !ext_pin |=> ext_flag_ff) else $error("falling edge not flagged");
    flag_no_enable_a: assert property (ext_edge && !irq_ctrl_ff[GIE_BIT]
        |=> ext_flag_ff && !irq_request) else $error("flag depends on enable");
    // only a software write or reset clears the flag; enables never touch it
    flag_sticky_a: assert property (ext_flag_ff && !reg_wr
        |=> ext_flag_ff) else $error("flag lost without clear");
    stack_rw_a: assert property (reg_wr && reg_addr == ADR_STACK_LO ##1 reg_rd
        && reg_addr == ADR_STACK_LO |=> reg_rdata == $past(reg_wdata, 2))
        else $error("stack window byte lost");
    stack_hi_wr_a: assert property (reg_wr && reg_addr == ADR_STACK_HI
        |=> stack_cur[15:8] == $past(reg_wdata)) else $error("window high byte lost");
    index_read_a: assert property (reg_rd && reg_addr == ADR_STACK_INDEX
        |=> reg_rdata == {3'h0, $past(stack_index_ff)}) else $error("index read");
    status_ro_a: assert property (reg_wr && reg_addr == ADR_STATUS_SHADOW
        && !irq_enter |=> status_shadow_ff[4:3] == $past(status_shadow_ff[4:3]))
        else $error("read-only shadow bits changed");
    timeout_flag_a: assert property (wdt_timeout |=> !status.watchdog_expiry_flag)
        else $error("time-out not shown");
    sleep_pd_a: assert property (sleep_exec |=> !status.powerdown_flag
        && status.watchdog_expiry_flag == !$past(wdt_timeout)) else $error("sleep flags");
    clear_flags_a: assert property (wdt_clear && !wdt_timeout && !sleep_exec
        |=> status.watchdog_expiry_flag && status.powerdown_flag)
        else $error("clear did not set flags");
    zero_flag_a: assert property (alu_valid && alu_op == ALU_ADD && !irq_return
        |=> status.zero == (8'($past(alu_a) + $past(alu_b)) == 8'h00))
        else $error("zero flag wrong");
    nib_carry_a: assert property (alu_valid && alu_op == ALU_ADD && !irq_return
        |=> status.nibble_carry_flag == ({1'b0, $past(alu_a[3:0])}
        + {1'b0, $past(alu_b[3:0])} > 5'h0f)) else $error("nibble carry wrong");
    add_carry_a: assert property (alu_valid && alu_op == ALU_ADD && !irq_return
        |=> status.carry == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff))
        else $error("add carry wrong");
    sub_carry_a: assert property (alu_valid && alu_op == ALU_SUB && !irq_return
        |=> status.carry == ($past(alu_a) >= $past(alu_b))) else $error("borrow wrong");
    rot_left_a: assert property (alu_valid && alu_op == ALU_ROTL && !irq_return
        |=> status.carry == $past(alu_a[7])) else $error("left rotate carry wrong");
    rot_right_a: assert property (alu_valid && alu_op == ALU_ROTR && !irq_return
        |=> status.carry == $past(alu_a[0])) else $error("right rotate carry wrong");
    save_restore_a: assert property (irq_enter ##1 (!reg_wr && !irq_enter)
        ##1 irq_return |=> restore_valid && restore_ctx == $past(core_ctx, 3))
        else $error("context lost");
    shadow_save_a: assert property (irq_enter |=> ctx_shadow_ff == $past(core_ctx)
        && status_shadow_ff == $past(status_ff)) else $error("entry save lost");
    restore_status_a: assert property (irq_return
        |=> status[2:0] == $past(status_shadow_ff[2:0])) else $error("status not restored");
    gie_block_a: assert property (!irq_ctrl_ff[GIE_BIT] |=> !irq_request)
        else $error("request with global enable off");
    gie_pass_a: assert property (ext_flag_ff && irq_ctrl_ff[EXT_EN_BIT]
        && irq_ctrl_ff[GIE_BIT] && !reg_wr |=> irq_request)
        else $error("enabled flag gave no request");
    cfg_rom_a: assert property (info_rd && info_addr == CFG_USER_ROWS
        |=> info_data == USER_ROW_COUNT) else $error("config word wrong");
    cfg_outside_a: assert property (info_rd && info_addr > CFG_INFO_LAST
        |=> info_data == 14'h0000) else $error("word outside regions");
    dev_uid_a: assert property (info_rd && info_addr == DEV_INFO_BASE
        |=> info_data == UID_SEED) else $error("identifier word wrong");

    // these check reset itself, so the default disable is overridden
    stack_reset_a: assert property (disable iff (1'b0) srst
        |=> stack_cur == STACK_RST && stack_index_ff == STACK_INDEX_RST)
        else $error("stack not cleared by reset");
    ctrl_reset_a: assert property (disable iff (1'b0) srst
        |=> irq_ctrl_ff == IRQ_CTRL_RST && !ext_flag_ff && !irq_request)
        else $error("control not reset");
    status_reset_a: assert property (disable iff (1'b0) srst
        |=> status == STATUS_RST && !restore_valid) else $error("status not reset");

    ext_irq_c: cover property (ext_edge ##1 irq_request);
    save_return_c: cover property (irq_enter ##[1:20] restore_valid);
    stack_walk_c: cover property (reg_wr && reg_addr == ADR_STACK_INDEX ##1
        reg_rd && reg_addr == ADR_STACK_HI);
    sleep_wake_c: cover property (sleep_exec ##[1:50] wdt_timeout);
    flag_clear_c: cover property (ext_irq_flag ##1 (reg_wr && reg_addr == ADR_IRQ_FLAG)
        ##1 !ext_irq_flag);
endmodule // csr_core_regs

// file: design/csr_pkg.sv
// csr_pkg: constants, types and field layout of the core shadow and stack register block.
// Assumes one clock domain, an 8-bit register port and a 14-bit information read port.
package csr_pkg;
    // register port addresses
    localparam logic [15:0] ADR_STATUS_SHADOW = 16'h1fe4;
    localparam logic [15:0] ADR_WORKING_SHADOW = 16'h1fe5;
    localparam logic [15:0] ADR_BANK_SHADOW = 16'h1fe6;
    localparam logic [15:0] ADR_PCL_SHADOW = 16'h1fe7;
    localparam logic [15:0] ADR_IND0_LO = 16'h1fe8;
    localparam logic [15:0] ADR_IND0_HI = 16'h1fe9;
    localparam logic [15:0] ADR_IND1_LO = 16'h1fea;
    localparam logic [15:0] ADR_IND1_HI = 16'h1feb;
    localparam logic [15:0] ADR_STACK_INDEX = 16'h1fed;
    localparam logic [15:0] ADR_STACK_LO = 16'h1fee;
    localparam logic [15:0] ADR_STACK_HI = 16'h1fef;
    localparam logic [15:0] ADR_IRQ_CTRL = 16'h1ff0;
    localparam logic [15:0] ADR_IRQ_FLAG = 16'h1ff1;
    localparam logic [15:0] ADR_STATUS_LIVE = 16'h1ff2;
    // interrupt control fields
    localparam int GIE_BIT = 7;
    localparam int EXT_EN_BIT = 1;
    localparam int EDGE_SEL_BIT = 0;
    localparam int EXT_FLAG_BIT = 0;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h01;
    // information regions
    localparam logic [15:0] DEV_INFO_BASE = 16'h8100;
    localparam logic [15:0] DEV_INFO_LAST = 16'h811f;
    localparam logic [15:0] CFG_INFO_BASE = 16'h8200;
    localparam logic [15:0] CFG_INFO_LAST = 16'h821f;
    localparam logic [15:0] CFG_ERASE_ROW = 16'h8200;
    localparam logic [15:0] CFG_WRITE_LATCH = 16'h8201;
    localparam logic [15:0] CFG_USER_ROWS = 16'h8202;
    localparam logic [15:0] CFG_EE_SIZE = 16'h8203;
    localparam logic [15:0] CFG_PIN_TOTAL = 16'h8204;
    localparam logic [13:0] ERASE_ROW_SIZE = 14'h0020;
    localparam logic [13:0] WRITE_LATCH_COUNT = 14'h0020;
    localparam logic [13:0] USER_ROW_COUNT = 14'h0080;
    localparam logic [13:0] EEPROM_SIZE = 14'h0100;
    // stack
    localparam int STACK_DEPTH = 32;
    localparam logic [15:0] STACK_RST = 16'h0000;
    localparam logic [4:0] STACK_INDEX_RST = 5'h00;

    // live status: watchdog expiry, power-down, zero, nibble carry, carry
    typedef struct packed {
        logic watchdog_expiry_flag;
        logic powerdown_flag;
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } csr_status_t;
    localparam csr_status_t STATUS_RST = 5'h18;

    // core context saved on interrupt entry
    typedef struct packed {
        logic [7:0] working;
        logic [5:0] bank;
        logic [6:0] pc_latch;
        logic [15:0] ind0;
        logic [15:0] ind1;
    } csr_ctx_t;

    typedef enum logic [4:0] {
        ALU_ADD = 5'b00001,
        ALU_SUB = 5'b00010,
        ALU_LOGIC = 5'b00100,
        ALU_ROTL = 5'b01000,
        ALU_ROTR = 5'b10000
    } csr_alu_op_t;
endpackage

// file: verification/csr_core_regs_tb_top.sv
// csr_core_regs_tb_top: self-checking bench for the core shadow and stack registers.
// Assumes the block answers reads one cycle after the strobe and events one cycle after pulse.
`timescale 1ns/100ps
module csr_core_regs_tb_top;
    import csr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = '0;
    logic [15:0] info_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic [7:0] alu_a = '0;
    logic [7:0] alu_b = '0;
    logic [7:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic info_rd = 1'b0;
    logic ext_pin = 1'b0;
    // event pulses: alu, sleep, clear, timeout, return, enter
    logic [5:0] ev = '0;
    csr_ctx_t core_ctx = '0;
    csr_ctx_t restore_ctx;
    csr_alu_op_t alu_op = ALU_ADD;
    logic [13:0] info_data;
    csr_status_t status;
    logic restore_valid;
    logic ext_irq_flag;
    logic irq_request;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] sa [7] = '{ADR_WORKING_SHADOW, ADR_BANK_SHADOW, ADR_PCL_SHADOW, ADR_IND0_LO,
        ADR_IND0_HI, ADR_IND1_LO, ADR_IND1_HI};
    logic [7:0] sw [7] = '{8'ha5, 8'hff, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0] se [7] = '{8'ha5, 8'h3f, 8'h7f, 8'h11, 8'h22, 8'h33, 8'h44};
    csr_alu_op_t t_op [10] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_ADD, ALU_LOGIC,
        ALU_LOGIC, ALU_ROTL, ALU_ROTR, ALU_ROTR};
    logic [7:0] t_a [10] = '{8'h0f, 8'hff, 8'h05, 8'h03, 8'h88, 8'h00, 8'h01, 8'h80, 8'h02, 8'h01};
    logic [7:0] t_b [10] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [4:0] t_m [10] = '{5'h07, 5'h07, 5'h07, 5'h07, 5'h07, 5'h04, 5'h04, 5'h01, 5'h01, 5'h01};
    logic [4:0] t_e [10] = '{5'h02, 5'h07, 5'h07, 5'h00, 5'h03, 5'h04, 5'h00, 5'h01, 5'h00, 5'h01};
    logic [5:0] w_ev [5] = '{6'h04, 6'h08, 6'h10, 6'h04, 6'h08};
    logic [1:0] w_ex [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3};

    csr_core_regs DUT (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .info_rd(info_rd), .info_addr(info_addr),
        .info_data(info_data), .irq_enter(ev[0]), .irq_return(ev[1]), .core_ctx(core_ctx),
        .wdt_timeout(ev[2]), .wdt_clear(ev[3]), .sleep_exec(ev[4]), .alu_valid(ev[5]),
        .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .ext_pin(ext_pin), .status(status),
        .restore_ctx(restore_ctx), .restore_valid(restore_valid), .ext_irq_flag(ext_irq_flag),
        .irq_request(irq_request)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [44:0] g, input logic [44:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask

    task automatic inf(input logic [15:0] a, input logic [13:0] e);
        @(posedge clk);
        info_rd <= 1'b1;
        info_addr <= a;
        @(posedge clk);
        info_rd <= 1'b0;
        #1;
        chk(info_data, e);
    endtask

    task automatic evt(input logic [5:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask

    task automatic pin(input logic v);
        @(posedge clk);
        ext_pin <= v;
        step(3);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(ADR_STACK_LO, 8'h00);
        rd(ADR_STACK_HI, 8'h00);
        rd(ADR_STACK_INDEX, 8'h00);
        rd(ADR_IRQ_CTRL, 8'h01);
        chk(status, 5'h18);
        $display("reset test done");
        core_ctx <= '{8'h3c, 6'h2a, 7'h55, 16'h1234, 16'hbeef};
        evt(6'h01);
        rd(ADR_WORKING_SHADOW, 8'h3c);
        rd(ADR_IND1_HI, 8'hbe);
        rd(ADR_STATUS_SHADOW, 8'h18);
        wr(ADR_STATUS_SHADOW, 8'hff);
        rd(ADR_STATUS_SHADOW, 8'h1f);
        for (int i = 0; i < 7; i++) wr(sa[i], sw[i]);
        for (int i = 0; i < 7; i++) rd(sa[i], se[i]);
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(sa[i], se[i]);
        evt(6'h02);
        chk(restore_valid, 1'b1);
        chk(restore_ctx, {8'ha5, 6'h3f, 7'h7f, 16'h2211, 16'h4433});
        chk(status, 5'h1f);
        step(1);
        chk(restore_valid, 1'b0);
        $display("shadow test done");
        wr(ADR_STACK_INDEX, 8'h03);
        wr(ADR_STACK_LO, 8'h11);
        wr(ADR_STACK_HI, 8'h22);
        wr(ADR_STACK_INDEX, 8'h1f);
        wr(ADR_STACK_LO, 8'h33);
        wr(ADR_STACK_HI, 8'h44);
        wr(ADR_STACK_INDEX, 8'h03);
        rd(ADR_STACK_LO, 8'h11);
        rd(ADR_STACK_HI, 8'h22);
        wr(ADR_STACK_INDEX, 8'hff);
        rd(ADR_STACK_INDEX, 8'h1f);
        rd(ADR_STACK_LO, 8'h33);
        rd(ADR_STACK_HI, 8'h44);
        $display("stack test done");
        for (int i = 0; i < 10; i++) begin
            alu_op <= t_op[i];
            alu_a <= t_a[i];
            alu_b <= t_b[i];
            evt(6'h20);
            chk(status & t_m[i], t_e[i]);
        end
        $display("alu test done");
        // expiry and power-down after timeout, clear, sleep, timeout, clear
        for (int i = 0; i < 5; i++) begin
            evt(w_ev[i]);
            chk(status[4:3], w_ex[i]);
        end
        $display("watchdog test done");
        pin(1'b1);
        chk(ext_irq_flag, 1'b1);
        chk(irq_request, 1'b0);
        wr(ADR_IRQ_FLAG, 8'h00);
        step(1);
        chk(ext_irq_flag, 1'b0);
        pin(1'b0);
        chk(ext_irq_flag, 1'b0);
        wr(ADR_IRQ_CTRL, 8'h00);
        pin(1'b1);
        chk(ext_irq_flag, 1'b0);
        pin(1'b0);
        chk(ext_irq_flag, 1'b1);
        wr(ADR_IRQ_CTRL, 8'h02);
        step(2);
        chk(irq_request, 1'b0);
        wr(ADR_IRQ_CTRL, 8'h82);
        step(2);
        chk(irq_request, 1'b1);
        wr(ADR_IRQ_CTRL, 8'h02);
        step(2);
        chk(irq_request, 1'b0);
        $display("interrupt test done");
        inf(CFG_ERASE_ROW, 14'h0020);
        inf(CFG_WRITE_LATCH, 14'h0020);
        inf(CFG_USER_ROWS, 14'h0080);
        inf(CFG_EE_SIZE, 14'h0100);
        inf(CFG_PIN_TOTAL, 14'h0014);
        wr(16'h8200, 8'h00);
        inf(CFG_ERASE_ROW, 14'h0020);
        inf(16'h8100, 14'h1a5c);
        inf(16'h8105, 14'h1a59);
        inf(16'h8300, 14'h0000);
        rd(16'h1fec, 8'h00);
        $display("information test done");
        print_verdict();
    end
endmodule // csr_core_regs_tb_top
